// ===== rtl/olpa_cfg_mem.sv
// olpa_cfg_mem: holds the words of the last loaded user configuration
// assumes one write port and one read port on the same clock
`timescale 1ns/10ps
module olpa_cfg_mem #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // write port
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  // read port
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata_reg
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem[raddr];
    end
  end
endmodule // olpa_cfg_mem

// ===== rtl/olpa_otp_loader.sv
// olpa_otp_loader: otp configuration loader, program assist and their control registers
// assumes the otp macro samples address and data while read or program is high
// Summary of operation
// - writing one to the reload bit starts a load of the chosen configuration
// - reload fires only on a new one after software wrote the bit to zero
// - a requested reload waits while the loader clock gate bit is one
// - the two-bit slot field picks which user configuration the reload reads
// - read mode resets to differential; the startup load is always differential
// - differential: mode word bit zero set at reset end, addresses shifted left one
// - single-ended: mode word bit zero cleared at reset end, addresses unchanged
// - read address setup lasts setup field plus one cycles
// - read strobe lasts pulse field plus one cycles; field resets to eleven
// - recovery after each read lasts recovery field plus one cycles; resets to ten
// - differential assist: even word gets data, odd word its inverse, bit zero ignored
// - single-ended assist: the given word alone is programmed, no inverse word
// - assist encoding has no effect on manual write commands
// - inter-step delay is delay field times 128 cycles; field resets to one
// - each word is tried up to the retry count, then the load failure flag sets
// - load failure flag is sticky and cleared by writing one
`timescale 1ns/10ps
module olpa_otp_loader
  import olpa_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // register port
  input  wire logic              ldr_wr,
  input  wire logic [LDR_W-1:0]  ldr_wdata,
  output logic      [LDR_W-1:0]  ldr_rdata,
  input  wire logic              pac_wr,
  input  wire logic [PAC_W-1:0]  pac_wdata,
  output logic      [PAC_W-1:0]  pac_rdata,
  input  wire logic              fail_clr,
  output logic                   load_fail,
  // loader status
  input  wire logic              loader_clock_gate_bit,
  output logic                   busy,
  output logic                   load_done,
  // loaded configuration readback
  input  wire logic [IDX_W-1:0]  cfg_rd_addr,
  output logic      [DATA_W-1:0] cfg_rd_data,
  // program assist request
  input  wire logic              pa_start,
  input  wire logic [ADDR_W-1:0] pa_addr,
  input  wire logic [DATA_W-1:0] pa_wdata,
  output logic                   pa_done,
  // manual write request
  input  wire logic              man_wr,
  input  wire logic [ADDR_W-1:0] man_addr,
  input  wire logic [DATA_W-1:0] man_wdata,
  // otp macro
  output logic                   mac_reset,
  output logic                   macro_mode_word_b0,
  output logic      [ADDR_W-1:0] mac_addr,
  output logic                   mac_read,
  output logic                   mac_pgm,
  output logic      [DATA_W-1:0] mac_wdata,
  input  wire logic [DATA_W-1:0] mac_rdata
);

  logic                 rst_meta_reg;
  logic                 rst_n;
  logic [LDR_W-1:0]     ldr_reg;
  logic [PAC_W-1:0]     pac_reg;
  olpa_state_e          state_reg;
  olpa_op_e             op_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic [CNT_W-1:0]     cur_last;
  logic [CNT_W-1:0]     delay_cyc;
  logic                 startup_pend_reg;
  logic                 reload_pend_reg;
  logic                 load_diff_reg;
  logic [SLOT_W-1:0]    slot_reg;
  logic [IDX_W-1:0]     idx_reg;
  logic                 pa_diff_reg;
  logic                 pa_second_reg;
  logic [ADDR_W-1:0]    pa_addr_reg;
  logic [DATA_W-1:0]    pa_wdata_reg;
  logic [TRY_W-1:0]     tries_reg;
  logic [ADDR_W-1:0]    man_addr_reg;
  logic [DATA_W-1:0]    man_wdata_reg;
  logic [DATA_W-1:0]    rd_data_reg;
  logic                 load_fail_reg;
  logic                 load_done_reg;
  logic                 pa_done_reg;
  logic                 mode_b0_reg;
  logic                 reload_trig;
  logic                 step_end;
  logic                 accept_start;
  logic                 accept_reload;
  logic                 verify_ok;
  logic                 pa_give_up;
  logic                 mem_we;
  logic [ADDR_W-1:0]    pa_cur_addr;
  logic [DATA_W-1:0]    pa_cur_data;
  logic [ADDR_W-1:0]    load_phys;
  logic [SLOT_W+IDX_W-1:0] load_log;

  // reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldr_reg <= LDR_RESET;
      pac_reg <= PAC_RESET;
    end else begin
      if (ldr_wr) begin
        ldr_reg <= ldr_wdata & LDR_WMASK;
      end
      if (pac_wr) begin
        pac_reg <= pac_wdata & PAC_WMASK;
      end
    end
  end

  assign ldr_rdata = ldr_reg;
  assign pac_rdata = pac_reg;

  // reload fires on a one written over a stored zero
  assign reload_trig   = ldr_wr && ldr_wdata[RELOAD_BIT] && !ldr_reg[RELOAD_BIT];
  assign accept_start  = (state_reg == ST_IDLE) && startup_pend_reg;
  assign accept_reload = (state_reg == ST_IDLE) && !startup_pend_reg && reload_pend_reg
                         && !loader_clock_gate_bit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startup_pend_reg <= 1'b1;
      reload_pend_reg  <= 1'b0;
    end else begin
      if (accept_start) begin
        startup_pend_reg <= 1'b0;
      end
      if (reload_trig) begin
        reload_pend_reg <= 1'b1;
      end else if (accept_reload) begin
        reload_pend_reg <= 1'b0;
      end
    end
  end

  // length of the current step
  assign delay_cyc = CNT_W'(pac_reg[DELAY_HI:DELAY_LO]) << DELAY_SHIFT;

  always_comb begin
    cur_last = CNT_ZERO;
    unique case (state_reg)
      ST_IDLE:  cur_last = CNT_ZERO;
      ST_ARST:  cur_last = CNT_ZERO;
      ST_SETUP: cur_last = CNT_W'(ldr_reg[TSETUP_BIT]);
      ST_PULSE: cur_last = CNT_W'(ldr_reg[TPULSE_HI:TPULSE_LO]);
      ST_RCVRY: cur_last = CNT_W'(ldr_reg[TRCVRY_HI:TRCVRY_LO]);
      ST_PGM:   cur_last = PGM_LAST;
      ST_PDLY:  cur_last = (delay_cyc == CNT_ZERO) ? CNT_ZERO : delay_cyc - CNT_ONE;
      ST_MWR:   cur_last = PGM_LAST;
    endcase
  end

  assign step_end = (cnt_reg == cur_last);

  // program assist target word
  assign pa_cur_addr = pa_second_reg ? {pa_addr_reg[ADDR_W-1:1], 1'b1} : pa_addr_reg;
  assign pa_cur_data = pa_second_reg ? ~pa_wdata_reg : pa_wdata_reg;
  assign verify_ok   = ((pa_cur_data & ~rd_data_reg) == '0);
  assign pa_give_up  = !verify_ok && (tries_reg >= pac_reg[RETRY_HI:RETRY_LO]);

  // sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      op_reg        <= OP_LOAD;
      cnt_reg       <= CNT_ZERO;
      load_diff_reg <= 1'b1;
      slot_reg      <= '0;
      idx_reg       <= '0;
      pa_diff_reg   <= 1'b1;
      pa_second_reg <= 1'b0;
      pa_addr_reg   <= '0;
      pa_wdata_reg  <= '0;
      tries_reg     <= '0;
      man_addr_reg  <= '0;
      man_wdata_reg <= '0;
      rd_data_reg   <= '0;
    end else begin
      cnt_reg <= step_end ? CNT_ZERO : cnt_reg + CNT_ONE;
      unique case (state_reg)
        ST_IDLE: begin
          cnt_reg <= CNT_ZERO;
          if (accept_start) begin
            op_reg        <= OP_LOAD;
            load_diff_reg <= 1'b1;
            slot_reg      <= '0;
            idx_reg       <= '0;
            state_reg     <= ST_ARST;
          end else if (accept_reload) begin
            op_reg        <= OP_LOAD;
            load_diff_reg <= !ldr_reg[RDMODE_BIT];
            slot_reg      <= ldr_reg[SLOT_HI:SLOT_LO];
            idx_reg       <= '0;
            state_reg     <= ST_ARST;
          end else if (pa_start) begin
            op_reg        <= OP_PA;
            pa_diff_reg   <= !pac_reg[PGM_MODE_BIT];
            pa_addr_reg   <= pac_reg[PGM_MODE_BIT] ? pa_addr
                             : {pa_addr[ADDR_W-1:1], 1'b0};
            pa_wdata_reg  <= pa_wdata;
            pa_second_reg <= 1'b0;
            tries_reg     <= '0;
            state_reg     <= ST_PGM;
          end else if (man_wr) begin
            man_addr_reg  <= man_addr;
            man_wdata_reg <= man_wdata;
            state_reg     <= ST_MWR;
          end
        end
        ST_ARST: begin
          state_reg <= ST_SETUP;
        end
        ST_SETUP: begin
          if (step_end) begin
            state_reg <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (step_end) begin
            rd_data_reg <= mac_rdata;
            state_reg   <= ST_RCVRY;
          end
        end
        ST_RCVRY: begin
          if (step_end) begin
            if (op_reg == OP_LOAD) begin
              idx_reg   <= idx_reg + IDX_W'(1);
              state_reg <= (idx_reg == IDX_LAST) ? ST_IDLE : ST_SETUP;
            end else if (verify_ok || pa_give_up) begin
              if (pa_diff_reg && !pa_second_reg) begin
                pa_second_reg <= 1'b1;
                tries_reg     <= '0;
                state_reg     <= ST_PGM;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else begin
              state_reg <= ST_PGM;
            end
          end
        end
        ST_PGM: begin
          if (step_end) begin
            tries_reg <= tries_reg + TRY_W'(1);
            state_reg <= ST_PDLY;
          end
        end
        ST_PDLY: begin
          if (step_end) begin
            state_reg <= ST_SETUP;
          end
        end
        ST_MWR: begin
          if (step_end) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // macro mode word bit zero follows the load encoding at reset end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_b0_reg <= 1'b1;
    end else if (state_reg == ST_ARST) begin
      mode_b0_reg <= load_diff_reg;
    end
  end

  // sticky failure flag, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_fail_reg <= 1'b0;
    end else if (state_reg == ST_RCVRY && step_end && op_reg == OP_PA && pa_give_up) begin
      load_fail_reg <= 1'b1;
    end else if (fail_clr) begin
      load_fail_reg <= 1'b0;
    end
  end

  // completion pulses
  assign mem_we = (state_reg == ST_RCVRY) && step_end && (op_reg == OP_LOAD);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_done_reg <= 1'b0;
      pa_done_reg   <= 1'b0;
    end else begin
      load_done_reg <= mem_we && (idx_reg == IDX_LAST);
      pa_done_reg   <= (state_reg == ST_RCVRY) && step_end && (op_reg == OP_PA)
                       && (verify_ok || pa_give_up) && !(pa_diff_reg && !pa_second_reg);
    end
  end

  // macro drive
  assign load_log  = {slot_reg, idx_reg};
  assign load_phys = load_diff_reg ? ADDR_W'({load_log, 1'b0}) : ADDR_W'(load_log);

  always_comb begin
    if (state_reg == ST_MWR) begin
      mac_addr  = man_addr_reg;
      mac_wdata = man_wdata_reg;
    end else if (op_reg == OP_PA) begin
      mac_addr  = pa_cur_addr;
      mac_wdata = pa_cur_data;
    end else begin
      mac_addr  = load_phys;
      mac_wdata = '0;
    end
  end

  assign mac_reset          = (state_reg == ST_ARST);
  assign mac_read           = (state_reg == ST_PULSE);
  assign mac_pgm            = (state_reg == ST_PGM) || (state_reg == ST_MWR);
  assign macro_mode_word_b0 = mode_b0_reg;
  assign busy               = (state_reg != ST_IDLE);
  assign load_done          = load_done_reg;
  assign pa_done            = pa_done_reg;
  assign load_fail          = load_fail_reg;

  olpa_cfg_mem #(
    .DEPTH (LOAD_WORDS),
    .WIDTH (DATA_W)
  ) u_cfg_mem (
    .clk       (clk),
    .rst_n     (rst_n),
    .we        (mem_we),
    .waddr     (idx_reg),
    .wdata     (rd_data_reg),
    .raddr     (cfg_rd_addr),
    .rdata_reg (cfg_rd_data)
  );

  // checks
  logic [CNT_W-1:0] rd_len_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_len_reg <= CNT_ZERO;
    end else begin
      rd_len_reg <= mac_read ? rd_len_reg + CNT_ONE : CNT_ZERO;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_reload_fires: assert property (
    ldr_wr && ldr_wdata[RELOAD_BIT] && !ldr_reg[RELOAD_BIT] |=> reload_pend_reg)
    else $error("reload write did not raise a pending load");

  chk_reload_rearm: assert property (
    ldr_wr && ldr_wdata[RELOAD_BIT] && ldr_reg[RELOAD_BIT] && !reload_pend_reg
    |=> !reload_pend_reg)
    else $error("reload fired without being rearmed");

  chk_gate_holds: assert property (
    state_reg == ST_IDLE && loader_clock_gate_bit && !startup_pend_reg
    |=> state_reg != ST_ARST)
    else $error("reload advanced while clock gate set");

  chk_startup_diff: assert property (
    accept_start |=> load_diff_reg ##1 macro_mode_word_b0)
    else $error("startup load not differential");

  chk_diff_addr: assert property (
    op_reg == OP_LOAD && mac_read && load_diff_reg
    |-> mac_addr == {2'b00, slot_reg, idx_reg, 1'b0})
    else $error("differential load address not shifted");

  chk_se_addr: assert property (
    op_reg == OP_LOAD && mac_read && !load_diff_reg |-> mac_addr == {3'b000, slot_reg, idx_reg})
    else $error("single-ended load address altered");

  chk_setup_len: assert property (
    $rose(mac_read) |-> $past(state_reg, 1) == ST_SETUP
    && $past(cnt_reg, 1) == CNT_W'(ldr_reg[TSETUP_BIT]))
    else $error("setup interval wrong");

  chk_pulse_len: assert property (
    $fell(mac_read) |-> rd_len_reg == CNT_W'(ldr_reg[TPULSE_HI:TPULSE_LO]) + CNT_ONE)
    else $error("read strobe width wrong");

  chk_pair_inverse: assert property (
    mac_pgm && state_reg == ST_PGM && pa_diff_reg
    |-> mac_addr[0] == pa_second_reg && (pa_second_reg ? mac_wdata == ~pa_wdata_reg
                                                       : mac_wdata == pa_wdata_reg))
    else $error("differential pair word or data wrong");

  chk_manual_raw: assert property (
    state_reg == ST_MWR |-> mac_addr == man_addr_reg && mac_wdata == man_wdata_reg)
    else $error("manual write altered by assist mode");

  chk_fail_sticky: assert property (
    load_fail && !fail_clr |=> load_fail)
    else $error("load failure flag dropped without clear");

  cov_reload: cover property (accept_reload ##[1:1000] load_done);
  cov_pa_pair: cover property (pa_start && busy == 1'b0 ##[1:1000] pa_done);
  cov_pa_fail: cover property ($rose(load_fail));
  cov_manual: cover property (state_reg == ST_MWR);

endmodule // olpa_otp_loader

// ===== rtl/olpa_pkg.sv
// olpa_pkg: constants, field layout and states of the otp loader and program assist
// assumes a 200 MHz system clock and a word-wide otp macro
package olpa_pkg;

  // clock
  localparam int CLK_PERIOD_PS  = 5000;

  // array and loader geometry
  localparam int ADDR_W         = 11;
  localparam int DATA_W         = 16;
  localparam int SLOT_W         = 2;
  localparam int IDX_W          = 6;
  localparam int LOAD_WORDS     = 64;
  localparam int CNT_W          = 9;
  localparam int TRY_W          = 4;

  // loader configuration register layout
  localparam int LDR_W          = 16;
  localparam int RELOAD_BIT     = 15;
  localparam int SLOT_HI        = 11;
  localparam int SLOT_LO        = 10;
  localparam int RDMODE_BIT     = 9;
  localparam int TSETUP_BIT     = 8;
  localparam int TPULSE_HI      = 7;
  localparam int TPULSE_LO      = 4;
  localparam int TRCVRY_HI      = 3;
  localparam int TRCVRY_LO      = 0;
  localparam logic [LDR_W-1:0] LDR_RESET = 16'h00BA;
  localparam logic [LDR_W-1:0] LDR_WMASK = 16'h8FFF;

  // program assist control register layout
  localparam int PAC_W          = 8;
  localparam int PGM_MODE_BIT   = 7;
  localparam int DELAY_HI       = 5;
  localparam int DELAY_LO       = 4;
  localparam int RETRY_HI       = 3;
  localparam int RETRY_LO       = 0;
  localparam logic [PAC_W-1:0] PAC_RESET = 8'h1A;
  localparam logic [PAC_W-1:0] PAC_WMASK = 8'hBF;

  // timing
  localparam int DELAY_UNIT_CYC = 128;
  localparam int DELAY_SHIFT    = $clog2(DELAY_UNIT_CYC);
  localparam int PGM_PULSE_PS   = 100000;
  localparam int PGM_PULSE_CYC  = (PGM_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] PGM_LAST = CNT_W'(PGM_PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 9'h001;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(LOAD_WORDS - 1);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ARST, ST_SETUP, ST_PULSE, ST_RCVRY, ST_PGM, ST_PDLY, ST_MWR
  } olpa_state_e;

  typedef enum logic {OP_LOAD, OP_PA} olpa_op_e;

endpackage

// ===== test/olpa_otp_loader_tb.sv
// olpa_otp_loader_tb: self-checking bench for the otp loader and program assist
// assumes the otp macro model and inputs driven on the falling clock edge
`timescale 1ns/10ps
module olpa_otp_loader_tb
  import olpa_pkg::*;
;
  localparam int TIMEOUT_CYC = 40000;
  logic              clk, rstn, ldr_wr, pac_wr, fail_clr, loader_clock_gate_bit;
  logic              pa_start, man_wr, busy, load_done, pa_done, load_fail, pgm_q;
  logic              mac_reset, macro_mode_word_b0, mac_read, mac_pgm;
  logic [LDR_W-1:0]  ldr_wdata, ldr_rdata;
  logic [PAC_W-1:0]  pac_wdata, pac_rdata;
  logic [IDX_W-1:0]  cfg_rd_addr;
  logic [DATA_W-1:0] cfg_rd_data, pa_wdata, man_wdata, mac_wdata, mac_rdata, stuck_mask;
  logic [ADDR_W-1:0] pa_addr, man_addr, mac_addr, first_a;
  logic [ADDR_W-1:0] pgm_aq[$];
  logic [DATA_W-1:0] pgm_dq[$];
  int                error_cnt, n_tests, cyc, hi, lo, n_ld, n_pd, n_rs;

  olpa_otp_loader dut (
    .clk, .rstn, .ldr_wr, .ldr_wdata, .ldr_rdata, .pac_wr, .pac_wdata, .pac_rdata,
    .fail_clr, .load_fail, .loader_clock_gate_bit, .busy, .load_done, .cfg_rd_addr,
    .cfg_rd_data, .pa_start, .pa_addr, .pa_wdata, .pa_done, .man_wr, .man_addr,
    .man_wdata, .mac_reset, .macro_mode_word_b0, .mac_addr, .mac_read, .mac_pgm,
    .mac_wdata, .mac_rdata
  );
  olpa_otp_model mem_model (
    .clk, .mac_addr, .mac_read, .mac_pgm, .mac_wdata, .mac_rdata, .stuck_mask
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // log every program pulse and count cycles of the one-cycle strobes
  always @(posedge clk) begin
    if (load_done === 1'b1) n_ld++;
    if (pa_done === 1'b1) n_pd++;
    if (mac_reset === 1'b1) n_rs++;
    pgm_q <= mac_pgm;
    if (mac_pgm === 1'b1 && pgm_q !== 1'b1) begin
      pgm_aq.push_back(mac_addr);
      pgm_dq.push_back(mac_wdata);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == TIMEOUT_CYC) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input bit p, input logic [LDR_W-1:0] v);
    @(negedge clk);
    ldr_wr = !p;
    pac_wr = p;
    ldr_wdata = v;
    pac_wdata = v[PAC_W-1:0];
    @(negedge clk);
    ldr_wr = 1'b0;
    pac_wr = 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(negedge clk);
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk(busy, 0);
  endtask

  // pulse width of read or program strobe, then low time up to the next read
  task automatic gap(input bit p);
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    while ((p ? mac_pgm : mac_read) !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    first_a = mac_addr;
    while ((p ? mac_pgm : mac_read) === 1'b1) begin
      @(negedge clk);
      hi++;
    end
    while (mac_read !== 1'b1 && lo < 2000) begin
      @(negedge clk);
      lo++;
    end
  endtask

  task automatic chk_cfg(input int slot, input bit se);
    for (int i = 0; i < LOAD_WORDS; i++) begin
      cfg_rd_addr = IDX_W'(i);
      @(negedge clk);
      chk(cfg_rd_data, mem_model.pat(se ? slot * 64 + i : slot * 128 + i * 2));
    end
  endtask

  task automatic pa_go(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    pgm_aq.delete();
    pgm_dq.delete();
    @(negedge clk);
    pa_start = 1'b1;
    pa_addr = a;
    pa_wdata = d;
    @(negedge clk);
    pa_start = 1'b0;
  endtask

  task automatic t_reset();
    chk(ldr_rdata, 16'h00BA);
    chk(pac_rdata, 8'h1A);
    chk(macro_mode_word_b0, 1);
    wait_idle();
    chk_cfg(0, 0);
    chk(n_ld, 1);
    chk(n_rs, 1);
    wr(0, 16'h70BA);
    chk(ldr_rdata, 16'h00BA);
    wr(1, 8'h5A);
    chk(pac_rdata, 8'h1A);
    $display("test reset done");
  endtask

  task automatic t_reload();
    wr(0, 16'h8932);
    gap(0);
    chk(hi, 4);
    chk(lo, 5);
    chk(first_a, 11'h100);
    wait_idle();
    chk_cfg(2, 0);
    chk(n_ld, 2);
    chk(macro_mode_word_b0, 1);
    wr(0, 16'h8932);
    repeat (8) @(negedge clk);
    chk(busy, 0);
    loader_clock_gate_bit = 1'b1;
    wr(0, 16'h0932);
    wr(0, 16'h8932);
    repeat (8) @(negedge clk);
    chk(busy, 0);
    loader_clock_gate_bit = 1'b0;
    repeat (3) @(negedge clk);
    chk(busy, 1);
    wait_idle();
    $display("test reload done");
  endtask

  task automatic t_single();
    wr(0, 16'h06BA);
    wr(0, 16'h86BA);
    gap(0);
    chk(first_a, 11'h040);
    chk(hi, 12);
    chk(lo, 12);
    wait_idle();
    chk_cfg(1, 1);
    chk(n_ld, 4);
    chk(n_rs, 4);
    chk(macro_mode_word_b0, 0);
    wr(0, 16'h00BA);
    $display("test single done");
  endtask

  task automatic t_assist();
    wr(1, 8'h2A);
    pa_go(11'h401, 16'h00F0);
    gap(1);
    chk(hi, 20);
    chk(lo, 257);
    wait_idle();
    chk(pgm_aq.size(), 2);
    chk(pgm_aq[0], 11'h400);
    chk(pgm_dq[0], 16'h00F0);
    chk(pgm_aq[1], 11'h401);
    chk(pgm_dq[1], 16'hFF0F);
    chk(load_fail, 0);
    stuck_mask = 16'h0001;
    wr(1, 8'hA3);
    pa_go(11'h403, 16'h0003);
    wait_idle();
    chk(pgm_aq.size(), 3);
    chk(pgm_aq[0], 11'h403);
    chk(pgm_aq[2], 11'h403);
    repeat (5) @(negedge clk);
    chk(n_pd, 2);
    chk(load_fail, 1);
    fail_clr = 1'b1;
    @(negedge clk);
    fail_clr = 1'b0;
    @(negedge clk);
    chk(load_fail, 0);
    stuck_mask = 16'h0000;
    $display("test assist done");
  endtask

  task automatic t_manual();
    wr(1, 8'h1A);
    pgm_aq.delete();
    pgm_dq.delete();
    @(negedge clk);
    man_wr = 1'b1;
    man_addr = 11'h405;
    man_wdata = 16'h1234;
    @(negedge clk);
    man_wr = 1'b0;
    wait_idle();
    chk(pgm_aq.size(), 1);
    chk(pgm_aq[0], 11'h405);
    chk(pgm_dq[0], 16'h1234);
    chk(n_pd, 2);
    chk(n_ld, 4);
    $display("test manual done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    {rstn, ldr_wr, pac_wr, fail_clr, loader_clock_gate_bit, pa_start, man_wr} = '0;
    {ldr_wdata, pac_wdata, cfg_rd_addr, pa_wdata, man_wdata, stuck_mask} = '0;
    {pa_addr, man_addr} = '0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_reload();
    t_single();
    t_assist();
    t_manual();
    tally_and_finish();
  end
endmodule // olpa_otp_loader_tb

// ===== test/olpa_otp_model.sv
// olpa_otp_model: behavioural otp array macro on the far side of the loader
// assumes the loader holds address and strobes steady across each clock edge
`timescale 1ns/10ps
module olpa_otp_model
  import olpa_pkg::*;
(
  // clock
  input  wire logic              clk,
  // macro pins
  input  wire logic [ADDR_W-1:0] mac_addr,
  input  wire logic              mac_read,
  input  wire logic              mac_pgm,
  input  wire logic [DATA_W-1:0] mac_wdata,
  output logic      [DATA_W-1:0] mac_rdata,
  // bits that refuse to program
  input  wire logic [DATA_W-1:0] stuck_mask
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] last_reg;

  // image held in the low part of the array, rest blank
  function automatic logic [DATA_W-1:0] pat(input int a);
    return (a < 512) ? (DATA_W'(a * 37) ^ 16'hA5C3) : 16'h0000;
  endfunction

  initial begin
    last_reg = 16'h0000;
    for (int a = 0; a < 2**ADDR_W; a++) mem[a] = pat(a);
  end

  // programming only ever sets bits
  always @(posedge clk) begin
    if (mac_pgm === 1'b1) mem[mac_addr] <= mem[mac_addr] | (mac_wdata & ~stuck_mask);
    last_reg <= mac_rdata;
  end

  // outside a read the bus toggles, so a stale sample never matches
  assign mac_rdata = (mac_read === 1'b1) ? mem[mac_addr] : ~last_reg;
endmodule // olpa_otp_model
